// ---- hdl/tdc_pkg.sv ----
package tdc_pkg;
    localparam logic [15:0] ADDR_CNT1 = 16'hff50;
    localparam logic [15:0] ADDR_CNT2 = 16'hff51;
    localparam logic [15:0] ADDR_CMP1 = 16'hff52;
    localparam logic [15:0] ADDR_CMP2 = 16'hff53;
    localparam logic [15:0] ADDR_CTL1 = 16'hff54;
    localparam logic [15:0] ADDR_CTL2 = 16'hff55;
    localparam logic [15:0] ADDR_SEL1 = 16'hff56;
    localparam logic [15:0] ADDR_SEL2 = 16'hff57;
    localparam int EN_BIT = 7;
    localparam int PWM_BIT = 6;
    localparam int CHAIN_BIT = 4;
    localparam int FHI_BIT = 3;
    localparam int FLO_BIT = 2;
    localparam int TOG_BIT = 1;
    localparam int GATE_BIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] CTL1_KEEP = 8'hc3;
    localparam logic [7:0] CTL2_KEEP = 8'hd3;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam logic [2:0] SEL_FALL = 3'h0;
    localparam logic [2:0] SEL_RISE = 3'h1;
    localparam logic [2:0] SEL_DIV4 = 3'h2;
    localparam logic [2:0] SEL_DIV8 = 3'h3;
    localparam logic [2:0] SEL_DIV16 = 3'h4;
    localparam logic [2:0] SEL_DIV32 = 3'h5;
    localparam logic [2:0] SEL_DIV128 = 3'h6;
    localparam logic [2:0] SEL_DIV512 = 3'h7;
    localparam int PRESC_W = 9;
endpackage

// ---- hdl/tdc_timer.sv ----
`timescale 1ns/1ps
module tdc_timer
    import tdc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic first_event_input,
    input wire logic second_event_input,
    output logic first_timer_output,
    output logic second_timer_output,
    output logic first_output_gate,
    output logic second_output_gate,
    output logic first_match_interrupt,
    output logic second_match_interrupt
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0][7:0] cnt;
        logic [1:0][7:0] cmp;
        logic [1:0][7:0] ctl;
        logic [1:0][2:0] sel;
        logic [1:0][PRESC_W-1:0] presc;
        logic [1:0][2:0] sync;
        logic [1:0] pend;
        logic [1:0] lat;
        logic [1:0] act;
        logic [1:0] out;
        logic [1:0] irq;
        logic [7:0] rdata;
    } tdc_state_t;

    tdc_state_t s_r;
    tdc_state_t s_nxt;

    logic chain;
    logic [1:0] run;
    logic [1:0] hold;
    logic [1:0] raw;
    logic [1:0] go;
    logic [1:0] zap;
    logic [1:0] hit;
    logic full;

    function automatic logic div_tick(input logic [2:0] code,
                                      input logic [PRESC_W-1:0] p);
        logic r;
        r = 1'b0;
        unique case (code)
            SEL_DIV4: r = &p[1:0];
            SEL_DIV8: r = &p[2:0];
            SEL_DIV16: r = &p[3:0];
            SEL_DIV32: r = &p[4:0];
            SEL_DIV128: r = &p[6:0];
            SEL_DIV512: r = &p[8:0];
            SEL_FALL, SEL_RISE: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] cnt_addr(input int n);
        return (n == 0) ? ADDR_CNT1 : ADDR_CNT2;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.irq = 2'b00;
        chain = s_r.ctl[1][CHAIN_BIT];
        for (int n = 0; n < 2; n++)
        begin
            s_nxt.sync[n] = {s_r.sync[n][1:0],
                (n == 0) ? first_event_input : second_event_input};
            unique case (s_r.sel[n])
                SEL_FALL: raw[n] = s_r.sync[n][2] & ~s_r.sync[n][1];
                SEL_RISE: raw[n] = s_r.sync[n][1] & ~s_r.sync[n][2];
                default: raw[n] = div_tick(s_r.sel[n], s_r.presc[n]);
            endcase
            run[n] = chain ? s_r.ctl[0][EN_BIT] : s_r.ctl[n][EN_BIT];
            zap[n] = chain ? ~s_r.ctl[0][EN_BIT] & ~s_r.ctl[1][EN_BIT]
                           : ~s_r.ctl[n][EN_BIT];
            hold[n] = bus_rd && (bus_addr == cnt_addr(n));
        end
        if (chain)
        begin
            hold[0] = hold[0] | hold[1];
            hold[1] = hold[0];
        end
        // a read stalls the count; the missed tick is applied next cycle
        go[0] = (raw[0] | s_r.pend[0]) & run[0] & ~hold[0];
        s_nxt.pend[0] = (raw[0] | s_r.pend[0]) & run[0] & hold[0];
        full = (s_r.cnt[0] == s_r.cmp[0]) && (s_r.cnt[1] == s_r.cmp[1]);
        if (chain)
        begin
            go[1] = go[0] && (s_r.cnt[0] == CNT_TOP) && !full;
            s_nxt.pend[1] = 1'b0;
            hit[0] = go[0] && full;
            hit[1] = go[1]
                && (8'(s_r.cnt[1] + 8'h01) == s_r.cmp[1]);
        end
        else
        begin
            go[1] = (raw[1] | s_r.pend[1]) & run[1] & ~hold[1];
            s_nxt.pend[1] = (raw[1] | s_r.pend[1]) & run[1] & hold[1];
            for (int n = 0; n < 2; n++)
                hit[n] = go[n] && !s_r.ctl[n][PWM_BIT]
                    && (s_r.cnt[n] == s_r.cmp[n]);
        end
        for (int n = 0; n < 2; n++)
        begin
            if (zap[n])
            begin
                s_nxt.cnt[n] = CNT_RESET;
                s_nxt.presc[n] = '0;
                s_nxt.pend[n] = 1'b0;
                s_nxt.act[n] = 1'b0;
            end
            else
            begin
                if (run[n])
                    s_nxt.presc[n] = PRESC_W'(s_r.presc[n] + 1'b1);
                if (hit[n] && !(chain && n == 1))
                    s_nxt.cnt[n] = CNT_RESET;
                else if (go[n])
                    s_nxt.cnt[n] = 8'(s_r.cnt[n] + 8'h01);
                if (go[n] && s_r.ctl[n][PWM_BIT] && !chain)
                begin
                    if (s_r.cnt[n] == s_r.cmp[n])
                        s_nxt.act[n] = 1'b0;
                    else if (s_r.cnt[n] == CNT_TOP)
                        s_nxt.act[n] = 1'b1;
                end
            end
            if (!run[n])
                s_nxt.act[n] = 1'b0;
            if (hit[n])
            begin
                s_nxt.irq[n] = 1'b1;
                if (s_r.ctl[n][TOG_BIT])
                    s_nxt.lat[n] = ~s_r.lat[n];
            end
        end
        if (chain && hit[0])
            s_nxt.cnt[1] = CNT_RESET;
        // ****************************************
        // register writes
        // ****************************************
        if (bus_wr)
        begin
            for (int n = 0; n < 2; n++)
            begin
                if (bus_addr == ((n == 0) ? ADDR_CTL1 : ADDR_CTL2))
                begin
                    s_nxt.ctl[n] = bus_wdata
                        & ((n == 0) ? CTL1_KEEP : CTL2_KEEP);
                    // code 11 is prohibited; treated as no change
                    if (bus_wdata[FHI_BIT] && !bus_wdata[FLO_BIT])
                        s_nxt.lat[n] = 1'b1;
                    else if (!bus_wdata[FHI_BIT] && bus_wdata[FLO_BIT])
                        s_nxt.lat[n] = 1'b0;
                end
                if (bus_addr == ((n == 0) ? ADDR_SEL1 : ADDR_SEL2))
                    s_nxt.sel[n] = bus_wdata[2:0];
                if (bus_addr == ((n == 0) ? ADDR_CMP1 : ADDR_CMP2))
                    s_nxt.cmp[n] = bus_wdata;
            end
        end
        for (int n = 0; n < 2; n++)
            s_nxt.out[n] = s_nxt.ctl[n][PWM_BIT]
                ? (s_nxt.act[n] ^ s_nxt.ctl[n][TOG_BIT])
                : s_nxt.lat[n];
        // ****************************************
        // register reads
        // ****************************************
        s_nxt.rdata = 8'h00;
        if (bus_rd)
        begin
            unique case (bus_addr)
                ADDR_CNT1: s_nxt.rdata = s_r.cnt[0];
                ADDR_CNT2: s_nxt.rdata = s_r.cnt[1];
                ADDR_CMP1: s_nxt.rdata = s_r.cmp[0];
                ADDR_CMP2: s_nxt.rdata = s_r.cmp[1];
                ADDR_CTL1: s_nxt.rdata = s_r.ctl[0];
                ADDR_CTL2: s_nxt.rdata = s_r.ctl[1];
                ADDR_SEL1: s_nxt.rdata = {5'h00, s_r.sel[0]};
                ADDR_SEL2: s_nxt.rdata = {5'h00, s_r.sel[1]};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.ctl <= {CTL_RESET, CTL_RESET};
            s_r.sel <= {SEL_RESET[2:0], SEL_RESET[2:0]};
            s_r.cnt <= {CNT_RESET, CNT_RESET};
            s_r.cmp <= {CMP_RESET, CMP_RESET};
        end
        else
            s_r <= s_nxt;
    end

    assign bus_rdata = s_r.rdata;
    assign first_timer_output = s_r.out[0];
    assign second_timer_output = s_r.out[1];
    assign first_output_gate = s_r.ctl[0][GATE_BIT];
    assign second_output_gate = s_r.ctl[1][GATE_BIT];
    assign first_match_interrupt = s_r.irq[0];
    assign second_match_interrupt = s_r.irq[1];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_pwm_stopped;
        s_r.ctl[0][PWM_BIT] && !s_r.ctl[0][EN_BIT] && !chain
        ##1 s_r.ctl[0][PWM_BIT] && !s_r.ctl[0][EN_BIT] && !chain;
    endsequence

    a_off_clears: assert property (
        !chain && !s_r.ctl[0][EN_BIT] |=> s_r.cnt[0] == 8'h00)
        else $error("stopped counter not cleared");
    a_match_irq: assert property (
        !chain && !$past(chain) && first_match_interrupt
        |-> $past(s_r.cnt[0]) == $past(s_r.cmp[0])
            && !$past(s_r.ctl[0][PWM_BIT]) && s_r.cnt[0] == 8'h00)
        else $error("interrupt without match");
    a_read_hold: assert property (
        bus_rd && bus_addr == ADDR_CNT1 && !bus_wr && s_r.ctl[0][EN_BIT]
        |=> s_r.cnt[0] == $past(s_r.cnt[0]))
        else $error("counter moved during read");
    a_force_zero: assert property (
        bus_rd && (bus_addr == ADDR_CTL1 || bus_addr == ADDR_CTL2)
        |=> bus_rdata[3:2] == 2'b00)
        else $error("force bits read nonzero");
    a_force_high: assert property (
        bus_wr && bus_addr == ADDR_CTL1 && bus_wdata[3:2] == 2'b10
        && !bus_wdata[PWM_BIT] |=> first_timer_output)
        else $error("force high failed");
    a_force_low: assert property (
        bus_wr && bus_addr == ADDR_CTL2 && bus_wdata[3:2] == 2'b01
        && !bus_wdata[PWM_BIT] |=> !second_timer_output)
        else $error("force low failed");
    a_pwm_inactive: assert property (
        s_pwm_stopped |-> first_timer_output == s_r.ctl[0][TOG_BIT])
        else $error("pwm output active while stopped");
    a_chain_hold: assert property (
        chain && !s_r.ctl[0][EN_BIT] && s_r.ctl[1][EN_BIT] && !bus_wr
        |=> s_r.cnt == $past(s_r.cnt))
        else $error("chained counter changed while stopped");
    a_square_toggle: assert property (
        !chain && first_match_interrupt && !$past(bus_wr)
        && !s_r.ctl[0][PWM_BIT] && $past(s_r.ctl[0][TOG_BIT])
        |-> first_timer_output != $past(first_timer_output))
        else $error("output did not toggle on match");
    a_sel_upper: assert property (
        bus_rd && bus_addr == ADDR_SEL1 |=> bus_rdata[7:3] == 5'h00)
        else $error("clock select upper bits nonzero");

    // ****************************************
    // checks on writes, steps and pulses
    // ****************************************
    // the reset values must be seen at the first edge after release
    a_reset_ctl: assert property (
        $past(rst) |-> s_r.ctl == 16'h0000 && s_r.sel == 6'h00)
        else $error("control not cleared by reset");
    a_reset_cnt: assert property (
        $past(rst) |-> s_r.cnt == 16'h0000)
        else $error("counters not cleared by reset");
    a_cnt1_step: assert property (
        !chain && s_r.ctl[0][EN_BIT]
        |=> s_r.cnt[0] == $past(s_r.cnt[0])
            || s_r.cnt[0] == 8'($past(s_r.cnt[0]) + 8'h01)
            || s_r.cnt[0] == 8'h00)
        else $error("first counter jumped");
    a_cnt2_step: assert property (
        !chain && s_r.ctl[1][EN_BIT]
        |=> s_r.cnt[1] == $past(s_r.cnt[1])
            || s_r.cnt[1] == 8'($past(s_r.cnt[1]) + 8'h01)
            || s_r.cnt[1] == 8'h00)
        else $error("second counter jumped");
    a_cnt_nowrite: assert property (
        bus_wr && bus_addr == ADDR_CNT1 && !chain && !s_r.ctl[0][EN_BIT]
        |=> s_r.cnt[0] == 8'h00)
        else $error("counter took a write");
    a_off_clears2: assert property (
        !chain && !s_r.ctl[1][EN_BIT] |=> s_r.cnt[1] == 8'h00)
        else $error("second stopped counter not cleared");
    a_presc_stop: assert property (
        !chain && !s_r.ctl[0][EN_BIT] |=> s_r.presc[0] == '0)
        else $error("prescaler runs while stopped");
    a_read_defer: assert property (
        !chain && raw[0] && run[0] && hold[0] |=> s_r.pend[0])
        else $error("tick lost during read");
    a_irq1_pulse: assert property (
        first_match_interrupt |=> !first_match_interrupt)
        else $error("first interrupt longer than a cycle");
    a_irq2_pulse: assert property (
        second_match_interrupt |=> !second_match_interrupt)
        else $error("second interrupt longer than a cycle");
    a_pwm1_no_irq: assert property (
        !chain && s_r.ctl[0][PWM_BIT] |=> !first_match_interrupt)
        else $error("first interrupt in pwm mode");
    a_pwm2_no_irq: assert property (
        !chain && s_r.ctl[1][PWM_BIT] |=> !second_match_interrupt)
        else $error("second interrupt in pwm mode");
    a_cmp1_write: assert property (
        bus_wr && bus_addr == ADDR_CMP1 |=> s_r.cmp[0] == $past(bus_wdata))
        else $error("first compare write lost");
    a_cmp2_write: assert property (
        bus_wr && bus_addr == ADDR_CMP2 |=> s_r.cmp[1] == $past(bus_wdata))
        else $error("second compare write lost");
    a_sel1_write: assert property (
        bus_wr && bus_addr == ADDR_SEL1
        |=> s_r.sel[0] == $past(bus_wdata[2:0]))
        else $error("first clock select write lost");
    a_sel2_write: assert property (
        bus_wr && bus_addr == ADDR_SEL2
        |=> s_r.sel[1] == $past(bus_wdata[2:0]))
        else $error("second clock select write lost");
    a_chain_cfg: assert property (
        bus_wr && bus_addr == ADDR_CTL2
        |=> chain == $past(bus_wdata[CHAIN_BIT]))
        else $error("chain bit not taken");
    a_gate1_write: assert property (
        bus_wr && bus_addr == ADDR_CTL1
        |=> first_output_gate == $past(bus_wdata[GATE_BIT]))
        else $error("first gate not taken");
    a_gate2_write: assert property (
        bus_wr && bus_addr == ADDR_CTL2
        |=> second_output_gate == $past(bus_wdata[GATE_BIT]))
        else $error("second gate not taken");
    a_ctl_unused: assert property (
        bus_rd && bus_addr == ADDR_CTL2 |=> !bus_rdata[5])
        else $error("unused control bit read nonzero");
    // a tick at the top turns the pulse on, one at the compare turns it off
    a_pwm_on: assert property (
        !chain && s_r.ctl[0][PWM_BIT] && go[0] && !bus_wr
        && s_r.cnt[0] == CNT_TOP && s_r.cmp[0] != CNT_TOP
        |=> first_timer_output == !s_r.ctl[0][TOG_BIT])
        else $error("pwm output not active after overflow");
    a_pwm_off: assert property (
        !chain && s_r.ctl[0][PWM_BIT] && go[0] && !bus_wr
        && s_r.cnt[0] == s_r.cmp[0]
        |=> first_timer_output == s_r.ctl[0][TOG_BIT])
        else $error("pwm output still active after match");
    a_chain_irq: assert property (
        chain && $past(chain) && first_match_interrupt
        |-> s_r.cnt == 16'h0000)
        else $error("chained match did not clear both");
    a_chain_upper: assert property (
        chain && s_r.cnt[0] != CNT_TOP && !full
        |=> s_r.cnt[1] == $past(s_r.cnt[1]) || s_r.cnt[1] == 8'h00)
        else $error("upper byte moved without a wrap");

endmodule // tdc_timer

// ---- bench/tdc_ev_src.sv ----
`timescale 1ns/1ps
// ************************************
// external event source
// ************************************
module tdc_ev_src
(
    input wire logic clk,
    input wire logic go,
    output logic ev,
    output int rises,
    output int falls
);
    int ph = 0;
    initial ev = 1'b0;
    initial rises = 0;
    initial falls = 0;
    // pin stands still while idle; a 4-clock half period stays below clk/4
    always @(posedge clk)
    begin
        if (go)
        begin
            ph <= ph + 1;
            if (ph % 4 == 3)
            begin
                ev <= ~ev;
                rises <= rises + (ev ? 0 : 1);
                falls <= falls + (ev ? 1 : 0);
            end
        end
    end
endmodule // tdc_ev_src

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench
    import tdc_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic go1 = 1'b0;
    logic ev1, ev2, to1, to2, g1, g2, irq1, irq2;
    int rises1, falls1, n_fail = 0, samples_checked = 0, n, m, k;
    int divs[8] = '{0, 0, 4, 8, 16, 32, 128, 512};
    always #5 clk = ~clk;
    tdc_timer DUT (.clk(clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .first_event_input(ev1),
        .second_event_input(ev2), .first_timer_output(to1),
        .second_timer_output(to2), .first_output_gate(g1),
        .second_output_gate(g2), .first_match_interrupt(irq1),
        .second_match_interrupt(irq2));
    tdc_ev_src src1 (.clk(clk), .go(go1), .ev(ev1), .rises(rises1),
        .falls(falls1));
    // second pin held idle: only the first timer counts events
    tdc_ev_src src2 (.clk(clk), .go(1'b0), .ev(ev2), .rises(), .falls());
    // ************************************
    // access and compare tasks
    // ************************************
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        d = bus_rdata;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            n_fail++;
            $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk8(d, exp);
    endtask
    // cycles until the chosen match pulse, bounded
    task automatic wirq(input bit sel, output int c);
        c = 0;
        do
        begin
            @(negedge clk);
            c++;
        end
        while (((sel ? irq2 : irq1) !== 1'b1) && c < 3000);
        if ((sel ? irq2 : irq1) !== 1'b1)
        begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ************************************
    // main sequence
    // ************************************
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (k = 0; k < 8; k++)
            rdc(ADDR_CNT1 + 16'(k), 8'h00);
        wr(ADDR_CTL1, 8'h7f);
        rdc(ADDR_CTL1, 8'h43);
        wr(ADDR_CTL2, 8'h7f);
        rdc(ADDR_CTL2, 8'h53);
        wr(ADDR_SEL1, 8'h07);
        rdc(ADDR_SEL1, 8'h07);
        wr(ADDR_CNT1, 8'h55);
        rdc(ADDR_CNT1, 8'h00);
        rdc(16'hff60, 8'h00);
        wr(ADDR_CTL2, 8'h00);
        // force codes 10, 01, 00 and the refused 11
        wr(ADDR_CTL1, 8'h09);
        repeat (2) @(negedge clk);
        chk8({7'h0, to1}, 8'h01);
        chk8({7'h0, g1}, 8'h01);
        wr(ADDR_CTL1, 8'h05);
        wr(ADDR_CTL1, 8'h01);
        repeat (2) @(negedge clk);
        chk8({7'h0, to1}, 8'h00);
        wr(ADDR_CTL1, 8'h09);
        wr(ADDR_CTL1, 8'h0d);
        repeat (2) @(negedge clk);
        chk8({7'h0, to1}, 8'h01);
        wr(ADDR_CTL2, 8'h09);
        wr(ADDR_CTL2, 8'h05);
        repeat (2) @(negedge clk);
        chk8({7'h0, to2}, 8'h00);
        chk8({7'h0, g2}, 8'h01);
        wr(ADDR_CTL2, 8'h09);
        repeat (2) @(negedge clk);
        chk8({7'h0, to2}, 8'h01);
        // square wave: interval (cmp+1) ticks of clk/4
        wr(ADDR_CTL1, 8'h00);
        wr(ADDR_SEL1, 8'h02);
        wr(ADDR_CMP1, 8'h03);
        wr(ADDR_CTL1, 8'h83);
        wirq(0, n);
        m = to1;
        wirq(0, n);
        chkn(n, 16);
        chk8({7'h0, to1}, {7'h0, ~m[0]});
        wr(ADDR_CMP1, 8'h07);
        wirq(0, n);
        // read while running, two cycles after the clear
        rdc(ADDR_CNT1, 8'h00);
        wirq(0, n);
        chkn(n, 30);
        wr(ADDR_CTL1, 8'h00);
        rdc(ADDR_CNT1, 8'h00);
        for (k = 2; k < 8; k++)
        begin
            wr(ADDR_CTL1, 8'h00);
            wr(ADDR_SEL1, 8'(k));
            wr(ADDR_CMP1, 8'h00);
            wr(ADDR_CTL1, 8'h80);
            wirq(0, n);
            wirq(0, n);
            chkn(n, divs[k]);
        end
        // pwm: one period is 256 ticks of 4 clocks, both polarities
        wr(ADDR_CTL1, 8'h00);
        wr(ADDR_SEL1, 8'h02);
        wr(ADDR_CMP1, 8'h40);
        for (k = 0; k < 2; k++)
        begin
            wr(ADDR_CTL1, k ? 8'hc3 : 8'hc1);
            repeat (1100) @(negedge clk);
            n = 0;
            m = 0;
            repeat (1024)
            begin
                @(negedge clk);
                n += (to1 === 1'b1);
                m += (irq1 === 1'b1);
            end
            chkn(n, k ? 764 : 260);
            chkn(m, 0);
            wr(ADDR_CTL1, k ? 8'h43 : 8'h41);
            repeat (2) @(negedge clk);
            chk8({7'h0, to1}, 8'(k));
        end
        // event counting on falling, then rising edges
        wr(ADDR_CMP1, 8'hff);
        for (k = 0; k < 2; k++)
        begin
            wr(ADDR_CTL1, 8'h00);
            wr(ADDR_SEL1, 8'(k));
            wr(ADDR_CTL1, 8'h80);
            n = k ? rises1 : falls1;
            go1 = 1'b1;
            repeat (60) @(negedge clk);
            go1 = 1'b0;
            repeat (10) @(negedge clk);
            rdc(ADDR_CNT1, 8'((k ? rises1 : falls1) - n));
        end
        // chained pair: 16-bit interval 0x0104 ticks
        wr(ADDR_CTL1, 8'h00);
        wr(ADDR_SEL1, 8'h02);
        wr(ADDR_CMP1, 8'h03);
        wr(ADDR_CMP2, 8'h01);
        wr(ADDR_CTL2, 8'h90);
        wr(ADDR_CTL1, 8'h80);
        wirq(0, n);
        wirq(0, n);
        chkn(n, 1040);
        wirq(1, n);
        wirq(1, n);
        chkn(n, 1040);
        // stop inside the 16 clocks that the count stands at 0100-0103
        repeat (2) @(negedge clk);
        wr(ADDR_CTL1, 8'h00);
        rdc(ADDR_CNT2, 8'h01);
        wr(ADDR_CTL2, 8'h00);
        rdc(ADDR_CNT2, 8'h00);
        rdc(ADDR_CNT1, 8'h00);
        wrap_up();
    end
endmodule // testbench
